// File: core/adc_mux_serial_control.sv
// Serial control of a sampling converter with a 4- or 8-input multiplexer
`timescale 1ns/100ps
`default_nettype none
`include "adc_mux_ctrl_cfg.svh"
module adc_mux_serial_control
   import adc_mux_ctrl_pkg::*;
#(
   parameter int NUM_CH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic shift_clk,
   input wire logic mux_select_n,
   input wire logic adc_select_n,
   input wire logic serial_in,
   input wire logic [11:0] adc_input_code,
   input wire logic [11:0] negative_input_code,
   output logic serial_out,
   output logic serial_oe,
   output logic adc_powered,
   output logic [7:0] chan_on
);
   localparam int BRK_CYC = (`BREAK_DELAY_NS * `CLK_MHZ + 999) / 1000;
   localparam int MAKE_CYC = (`MAKE_DELAY_NS * `CLK_MHZ + 999) / 1000;

   // ---------------- Link side, on the host shift clock ----------------
   chan_word_t word_q;
   logic [4:0] fcnt_q;
   logic [11:0] result_q;
   logic serial_out_q;
   logic serial_oe_q;
   logic adc_on_q;
   logic [11:0] diff_code;
   logic conv_rst_n;

   // Converter select high holds the converter logic in reset
   assign conv_rst_n = rstn & ~adc_select_n;

   // Unipolar: a negative difference cannot be shown, so it reads as zero
   always_comb begin
      if (adc_input_code >= negative_input_code) begin
         diff_code = adc_input_code - negative_input_code;
      end else begin
         diff_code = `RESULT_RESET;
      end
   end

   // Word loads even while the converter is powered down
   always_ff @(posedge shift_clk or negedge rstn) begin
      if (!rstn) begin
         word_q <= `WORD_RESET;
      end else if (mux_select_n) begin
         word_q <= {word_q[2:0], serial_in};
      end
   end

   always_ff @(negedge shift_clk or negedge conv_rst_n) begin
      if (!conv_rst_n) begin
         fcnt_q <= 5'h00;
      end else if (fcnt_q != `FALL_CNT_MAX) begin
         fcnt_q <= fcnt_q + 5'h01;
      end
   end

   // Hold on the second falling edge; the code is frozen there
   always_ff @(negedge shift_clk or negedge conv_rst_n) begin
      if (!conv_rst_n) begin
         result_q <= `RESULT_RESET;
      end else if (fcnt_q == `NULL_FALL - 5'h01) begin
         result_q <= diff_code;
      end
   end

   // Powered from the first falling edge after select until the fourteenth; off while deselected
   always_ff @(negedge shift_clk or negedge conv_rst_n) begin
      if (!conv_rst_n) begin
         adc_on_q <= 1'b0;
      end else if (fcnt_q == 5'h00) begin
         adc_on_q <= 1'b1;
      end else if (fcnt_q == `NULL_FALL + 5'(`CONV_CYCLES) - 5'h01) begin
         adc_on_q <= 1'b0;
      end
   end

   always_ff @(negedge shift_clk or negedge conv_rst_n) begin
      if (!conv_rst_n) begin
         serial_oe_q <= 1'b0;
      end else if (fcnt_q == `NULL_FALL - 5'h01) begin
         serial_oe_q <= 1'b1;
      end
   end

   // Null bit, MSB-first result, LSB-first repeat, then zeros
   always_ff @(negedge shift_clk or negedge conv_rst_n) begin
      if (!conv_rst_n) begin
         serial_out_q <= 1'b0;
      end else if (fcnt_q == `NULL_FALL - 5'h01) begin
         serial_out_q <= 1'b0;
      end else if (fcnt_q >= `NULL_FALL && fcnt_q <= `NULL_FALL + 5'h0b) begin
         serial_out_q <= result_q[4'(5'h0d - fcnt_q)];
      end else if (fcnt_q >= `NULL_FALL + 5'h0c && fcnt_q <= `LSB_FIRST_END) begin
         serial_out_q <= result_q[4'(fcnt_q - 5'h0d)];
      end else begin
         serial_out_q <= 1'b0;
      end
   end

   assign serial_out = serial_out_q;
   assign serial_oe = serial_oe_q;
   assign adc_powered = adc_on_q;

   // ---------------- Switch timing, on the system clock ----------------
   logic msel_s1_q;
   logic msel_s2_q;
   logic msel_s3_q;
   logic fall_evt;
   switch_state_t sw_state_q;
   logic [7:0] sw_cnt_q;
   chan_word_t held_q;
   logic [7:0] chan_on_q;
   logic [7:0] decoded;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         msel_s1_q <= 1'b1;
         msel_s2_q <= 1'b1;
         msel_s3_q <= 1'b1;
      end else begin
         msel_s1_q <= mux_select_n;
         msel_s2_q <= msel_s1_q;
         msel_s3_q <= msel_s2_q;
      end
   end

   assign fall_evt = msel_s3_q & ~msel_s2_q;

   // Word is static once select is low, so a late capture is safe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         held_q <= `WORD_RESET;
      end else if (fall_evt) begin
         held_q <= word_q;
      end
   end

   always_comb begin
      decoded = `CHAN_ALL_OFF;
      if (held_q.channel_enable_bit && (NUM_CH == 8 || !held_q.channel_address[2])) begin
         decoded = 8'h01 << held_q.channel_address;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sw_state_q <= SW_IDLE;
         sw_cnt_q <= 8'h00;
      end else if (fall_evt) begin
         sw_state_q <= SW_BREAK;
         sw_cnt_q <= 8'h00;
      end else begin
         unique case (sw_state_q)
            SW_IDLE: begin
               sw_cnt_q <= 8'h00;
            end
            SW_BREAK: begin
               sw_cnt_q <= sw_cnt_q + 8'h01;
               if (sw_cnt_q == 8'(BRK_CYC - 1)) begin
                  sw_state_q <= held_q.channel_enable_bit ? SW_MAKE : SW_IDLE;
               end
            end
            SW_MAKE: begin
               sw_cnt_q <= sw_cnt_q + 8'h01;
               if (sw_cnt_q == 8'(MAKE_CYC - 1)) begin
                  sw_state_q <= SW_IDLE;
               end
            end
         endcase
      end
   end

   // Off first, on later: never two inputs joined at once
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chan_on_q <= `CHAN_ALL_OFF;
      end else if (sw_state_q == SW_BREAK && sw_cnt_q == 8'(BRK_CYC - 1)) begin
         chan_on_q <= `CHAN_ALL_OFF;
      end else if (sw_state_q == SW_MAKE && sw_cnt_q == 8'(MAKE_CYC - 1)) begin
         chan_on_q <= decoded;
      end
   end

   assign chan_on = chan_on_q;

   // Cycles since the synced select fall; only the switch timing checks read it
   logic [7:0] since_fall_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         since_fall_q <= 8'hff;
      end else if (fall_evt) begin
         since_fall_q <= 8'h00;
      end else if (since_fall_q != 8'hff) begin
         since_fall_q <= since_fall_q + 8'h01;
      end
   end

   // ---------------- Checks ----------------
   // Link side: word checks on rising shift-clock edges, output checks counted in falling edges
   a_word_shift: assert property (@(posedge shift_clk) disable iff (!rstn)
      mux_select_n |=> word_q[0] == $past(serial_in))
      else $error("channel word did not shift in serial_in");

   a_word_hold: assert property (@(posedge shift_clk) disable iff (!rstn)
      !mux_select_n |=> $stable(word_q))
      else $error("channel word moved while select was low");

   a_null_first: assert property (@(negedge shift_clk) disable iff (!conv_rst_n)
      fcnt_q == `NULL_FALL |-> serial_oe_q && !serial_out_q)
      else $error("null bit missing");

   a_oe_by_sixth: assert property (@(negedge shift_clk) disable iff (!conv_rst_n)
      fcnt_q >= 5'h05 |-> serial_oe_q)
      else $error("data wire not driven by sixth falling edge");

   a_msb_out: assert property (@(negedge shift_clk) disable iff (!conv_rst_n)
      fcnt_q == `NULL_FALL + 5'h01 |-> serial_out_q == result_q[11] && result_q == $past(diff_code, 2))
      else $error("first result bit wrong");

   a_result_zero: assert property (@(negedge shift_clk) disable iff (!conv_rst_n)
      fcnt_q == `NULL_FALL && $past(adc_input_code) < $past(negative_input_code)
      |-> result_q == `RESULT_RESET)
      else $error("negative difference not read as zero");

   a_conv_len: assert property (@(negedge shift_clk) disable iff (!conv_rst_n)
      $fell(adc_on_q) |-> fcnt_q == `NULL_FALL + 5'(`CONV_CYCLES))
      else $error("conversion length not twelve cycles");

   a_lsb_first: assert property (@(negedge shift_clk) disable iff (!conv_rst_n)
      fcnt_q == `NULL_FALL + 5'h0d |-> serial_out_q == result_q[1] && !adc_on_q)
      else $error("lsb-first tail wrong");

   a_tail_zero: assert property (@(negedge shift_clk) disable iff (!conv_rst_n)
      fcnt_q > `LSB_FIRST_END + 5'h01 |-> !serial_out_q)
      else $error("zeros not sent after lsb-first tail");

   // Converter select high: converter off, wire released
   a_idle_off: assert property (@(posedge clk) disable iff (!rstn)
      adc_select_n |-> !adc_on_q)
      else $error("converter powered while deselected");

   a_wire_free: assert property (@(posedge clk) disable iff (!rstn)
      adc_select_n |-> !serial_oe_q)
      else $error("data wire driven while deselected");

   // Switch timing, counted in system clocks from the synced select fall
   a_held_word: assert property (@(posedge clk) disable iff (!rstn)
      fall_evt |=> held_q == $past(word_q))
      else $error("channel word not taken at select fall");

   a_break_off: assert property (@(posedge clk) disable iff (!rstn)
      since_fall_q == 8'(BRK_CYC) |-> chan_on_q == `CHAN_ALL_OFF)
      else $error("channels not off after break delay");

   a_break_gap: assert property (@(posedge clk) disable iff (!rstn)
      since_fall_q > 8'(BRK_CYC) && since_fall_q < 8'(MAKE_CYC) |-> chan_on_q == `CHAN_ALL_OFF)
      else $error("channel made inside break interval");

   a_make_on: assert property (@(posedge clk) disable iff (!rstn)
      since_fall_q >= 8'(MAKE_CYC) |-> chan_on_q == decoded)
      else $error("channel not made after make delay");

   a_off_stays: assert property (@(posedge clk) disable iff (!rstn)
      since_fall_q >= 8'(BRK_CYC) && !held_q.channel_enable_bit |-> chan_on_q == `CHAN_ALL_OFF)
      else $error("channel on after disable word");

   a_one_hot: assert property (@(posedge clk) disable iff (!rstn)
      $onehot0(chan_on_q))
      else $error("two channels connected at once");

   a_four_off: assert property (@(posedge clk) disable iff (!rstn)
      NUM_CH == 4 |-> chan_on_q[7:4] == 4'h0)
      else $error("upper channel on in four-input part");

   a_chan_hold: assert property (@(posedge clk) disable iff (!rstn)
      sw_state_q == SW_IDLE |=> $stable(chan_on_q))
      else $error("channel changed without select fall");
endmodule : adc_mux_serial_control
`default_nettype wire

// File: core/adc_mux_ctrl_cfg.svh
// Constants for the multiplexer and converter serial control block
`ifndef ADC_MUX_CTRL_CFG_SVH
`define ADC_MUX_CTRL_CFG_SVH
`define CLK_MHZ 125
`define BREAK_DELAY_NS 200
`define MAKE_DELAY_NS 400
`define WORD_BITS 4
`define RESULT_BITS 12
`define NULL_FALL 5'h02
`define CONV_CYCLES 12
`define LSB_FIRST_END 5'h18
`define FALL_CNT_MAX 5'h1f
`define CHAN_ALL_OFF 8'h00
`define WORD_RESET 4'h0
`define RESULT_RESET 12'h000
`endif

// File: core/adc_mux_ctrl_pkg.sv
// Types shared by the multiplexer and converter serial control block
package adc_mux_ctrl_pkg;
   typedef struct packed {
      logic channel_enable_bit;
      logic [2:0] channel_address;
   } chan_word_t;
   typedef enum logic [1:0] {
      SW_IDLE,
      SW_BREAK,
      SW_MAKE
   } switch_state_t;
endpackage : adc_mux_ctrl_pkg

// File: testbench/host_port.sv
// Host serial port model: shift clock, selects and data wire
`timescale 1ns/100ps
`default_nettype none
module host_port (
   output logic shift_clk,
   output logic mux_select_n,
   output logic adc_select_n,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_oe,
   input wire logic adc_powered
);
   logic [27:0] rx;
   logic [27:0] oe;
   logic [27:0] pw;
   initial begin
      shift_clk = 0;
      mux_select_n = 1;
      adc_select_n = 1;
      serial_in = 0;
   end
   // Clock idles low; stands still between frames
   task automatic frame(input logic [5:0] w, input int n, input logic mx, input logic ad);
      for (int i = n - 1; i >= 0; i--) begin
         serial_in = w[i];
         #7.5 shift_clk = 1;
         #7.5 shift_clk = 0;
      end
      // Selects move mid low phase, clear of the edge that starts the count
      #3.75 mux_select_n = ~mx;
      adc_select_n = ~ad;
      // Port turned to input; stale level not kept
      serial_in = ~serial_in;
      for (int k = 0; k < 28; k++) begin
         #7.5 shift_clk = 1;
         rx[k] = serial_out;
         oe[k] = serial_oe;
         pw[k] = adc_powered;
         #7.5 shift_clk = 0;
      end
      #7.5 mux_select_n = 1;
      adc_select_n = 1;
   endtask : frame
endmodule : host_port
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the serial control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk, rstn, sclk, mux_n, adc_n, sin, sout, soe, pwr;
   logic [11:0] pos, neg;
   logic [7:0] chan_on;
   logic [7:0] chan_four;
   int n_mismatch, check_count;
   adc_mux_serial_control uut (.clk(clk), .rstn(rstn), .shift_clk(sclk),
      .mux_select_n(mux_n), .adc_select_n(adc_n), .serial_in(sin),
      .adc_input_code(pos), .negative_input_code(neg), .serial_out(sout),
      .serial_oe(soe), .adc_powered(pwr), .chan_on(chan_on));
   // Four-input build on the same link; only its switches are compared
   adc_mux_serial_control #(.NUM_CH(4)) uut_four (.clk(clk), .rstn(rstn), .shift_clk(sclk),
      .mux_select_n(mux_n), .adc_select_n(adc_n), .serial_in(sin),
      .adc_input_code(pos), .negative_input_code(neg), .serial_out(),
      .serial_oe(), .adc_powered(), .chan_on(chan_four));
   host_port host (.shift_clk(sclk), .mux_select_n(mux_n), .adc_select_n(adc_n),
      .serial_in(sin), .serial_out(sout), .serial_oe(soe), .adc_powered(pwr));
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic run(input logic [5:0] w, input int n, input logic mx, input logic ad,
         input logic [11:0] p, input logic [11:0] m, input logic [7:0] ch);
      logic [11:0] r;
      @(posedge clk);
      pos <= p;
      neg <= m;
      r = (p > m) ? p - m : 12'h000;
      host.frame(w, n, mx, ad);
      // Switching settles within ~53 clk of the select fall
      repeat (90) @(posedge clk);
      check(chan_on, ch);
      check(chan_four, ch & 8'h0f);
      if (ad) begin
         check(host.rx[2], 0);
         check(host.oe[5], 1);
         for (int k = 3; k < 15; k++) check(host.rx[k], r[14-k]);
         for (int k = 15; k < 26; k++) check(host.rx[k], r[k-14]);
         check(host.rx[27], 0);
         check(host.pw[20], 0);
         check(host.pw[1], 1);
         check(host.pw[13], 1);
         check(host.pw[14], 0);
      end else begin
         check(host.oe, 0);
         check(host.pw, 0);
      end
      $display("test word %h done", w);
   endtask : run
   task automatic t_channels();
      for (int c = 0; c < 8; c++)
         run({3'b001, c[2:0]}, 4, 1, 1, 12'hfff - c[11:0], c[11:0], 8'h01 << c);
   endtask : t_channels
   task automatic t_off_clamp();
      run(6'h07, 4, 1, 1, 12'h123, 12'h200, 8'h00);
   endtask : t_off_clamp
   task automatic t_long_word();
      run(6'h2c, 6, 1, 1, 12'h5a5, 12'h000, 8'h10);
   endtask : t_long_word
   task automatic t_split_selects();
      run(6'h09, 4, 1, 0, 12'h000, 12'h000, 8'h02);
      run(6'h0e, 4, 0, 1, 12'h3c3, 12'h011, 8'h02);
   endtask : t_split_selects
   initial begin
      rstn = 0;
      pos = 12'h000;
      neg = 12'h000;
      repeat (3) @(posedge clk);
      rstn <= 1;
      repeat (3) @(posedge clk);
      t_channels();
      t_off_clamp();
      t_long_word();
      t_split_selects();
      print_verdict();
   end
   initial begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
